/* verilog/clk_src_regs.svh */
// Purpose: Register offsets, field positions and reset values of the clock source selector
// Assumes: Included by its bare name from every file that decodes the registers
// Notes:   Definitions only
`ifndef CLK_SRC_REGS_SVH
`define CLK_SRC_REGS_SVH

// ==========================================================================
// Register offsets
`define OFS_SYSTEM_CONTROL   8'h00
`define OFS_PLL_CONTROL      8'h04
`define OFS_PLL_OUT_DIVIDE   8'h08
`define OFS_CLOCK_STATUS     8'h0C

// ==========================================================================
// Field positions and widths
`define SEL_LSB              0
`define SEL_W                2
`define BYPASS_BIT           0
`define OSC_INTERNAL_BIT     1
`define PRESCALE_LSB         4
`define PRESCALE_W           10
`define PLL_IN_DIV_LSB       16
`define PLL_IN_DIV_W         4
`define PLL_MUL_LSB          20
`define PLL_MUL_W            8
`define PLL_OUT_DIV_LSB      0
`define PLL_OUT_DIV_W        7

// ==========================================================================
// Reset values
`define SYSTEM_CONTROL_RST   32'h0000_0000
`define PLL_CONTROL_RST      32'h0000_0001
`define PLL_OUT_DIVIDE_RST   32'h0000_0000

// ==========================================================================
// Source select codes and limits
`define SEL_WAKEUP           2'h0
`define SEL_PRESCALE_PLL     2'h2
`define SEL_DIRECT           2'h3
`define PRESCALE_MAX         11'h400

`endif

/* verilog/clk_src_pkg.sv */
// Purpose: Types shared by the clock source selector and its helpers
// Assumes: Field widths match clk_src_regs.svh
// Notes:   Types only
`default_nettype none
package clk_src_pkg;

  // ==========================================================================
  // Clock configuration as held by software and as applied
  typedef struct packed {
    logic [1:0] clock_source_select;
    logic       vco_bypass;
    logic       osc_internal;
    logic [9:0] prescale_divide_field;
    logic [3:0] pll_input_divide_field;
    logic [7:0] pll_multiplier_field;
    logic [6:0] pll_output_divide_field;
  } clk_cfg_t;

  // One-cycle edge events of a sampled clock
  typedef struct packed {
    logic rise;
    logic fall;
  } clk_edge_t;

  // Generation mechanism
  typedef enum logic [1:0] {
    MODE_WAKEUP,
    MODE_DIRECT,
    MODE_PRESCALE,
    MODE_PLL
  } clk_mode_t;

endpackage
`default_nettype wire

/* verilog/edge_divider.sv */
// Purpose: Divides an edge stream by a programmable factor of field plus one
// Assumes: Edge events are one-cycle pulses in the core clock domain
// Notes:   Factor one passes source edges straight through
`timescale 1ns/100ps
`default_nettype none
module edge_divider
  import clk_src_pkg::*;
#(
  parameter int WIDTH = 10
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Control
  input  wire logic             restart,
  input  wire logic [WIDTH-1:0] div_m1,
  // Edges
  input  var  clk_edge_t        src,
  output var  clk_edge_t        out
);

  logic [WIDTH-1:0] cnt;
  logic [WIDTH:0]   half;

  // ==========================================================================
  // Fall point at half the factor
  assign half = ({1'b0, div_m1} + {{WIDTH{1'b0}}, 1'b1}) >> 1;

  // Output edges
  always_comb begin
    if (div_m1 == '0) begin
      out = src;
    end else begin
      out.rise = src.rise && (cnt == '0);
      out.fall = src.rise && (cnt == half[WIDTH-1:0]);
    end
  end

  // Source rise counter
  always_ff @(posedge clk) begin
    if (!rst_n || restart) begin
      cnt <= '0;
    end else if (src.rise) begin
      cnt <= (cnt == div_m1) ? '0 : cnt + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule
`default_nettype wire

/* verilog/rate_nco.sv */
// Purpose: Frequency synthesiser locked to a sampled input clock, rate N over P times K2
// Assumes: Input rises are one-cycle pulses; output rate stays below half the core clock
// Notes:   Input period is measured in core cycles and refreshed at every input rise
`timescale 1ns/100ps
`default_nettype none
module rate_nco
  import clk_src_pkg::*;
#(
  parameter int PW = 16
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Control
  input  wire logic       restart,
  input  wire logic [7:0] n_m1,
  input  wire logic [3:0] p_m1,
  input  wire logic [6:0] k2_m1,
  // Edges
  input  wire logic       src_rise,
  output var  clk_edge_t  out
);

  logic [PW-1:0]   period_cnt;
  logic [PW-1:0]   period;
  logic [PW+12:0]  thr;
  logic [PW+13:0]  acc;
  logic [PW+13:0]  sum;
  logic [PW+13:0]  rem;
  logic            wrap;
  logic            phase;

  // ==========================================================================
  // Threshold P*K2*period and increment 2*N per core cycle
  assign thr  = (PW+13)'({1'b0, p_m1} + 5'h01) * (PW+13)'({1'b0, k2_m1} + 8'h01)
              * (PW+13)'(period);
  assign sum  = acc + (PW+14)'({1'b0, n_m1} + 9'h001) * (PW+14)'(2);
  assign wrap = (period != '0) && (sum >= {1'b0, thr});
  assign rem  = sum - {1'b0, thr};

  // Output edges on each half-period wrap
  always_comb begin
    out.rise = wrap && !phase;
    out.fall = wrap && phase;
  end

  // Input period measurement
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      period_cnt <= '0;
      period     <= '0;
    end else if (src_rise) begin
      period_cnt <= '0;
      period     <= period_cnt + {{(PW-1){1'b0}}, 1'b1};
    end else if (period_cnt != '1) begin
      period_cnt <= period_cnt + {{(PW-1){1'b0}}, 1'b1};
    end
  end

  // Phase accumulator
  always_ff @(posedge clk) begin
    if (!rst_n || restart || period == '0) begin
      acc   <= '0;
      phase <= 1'b0;
    end else if (wrap) begin
      acc   <= (rem >= {1'b0, thr}) ? '0 : rem;
      phase <= !phase;
    end else begin
      acc <= sum;
    end
  end

  // ==========================================================================
  // Checks
  remainder_below_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wrap && !restart) ##1 $stable(thr) |-> acc < {1'b0, thr})
    else $error("accumulator remainder not below threshold");

endmodule
`default_nettype wire

/* verilog/system_clock_source_select.sv */
// Purpose: Selects and divides the source of the system clock
// Assumes: All clock inputs are sampled levels synchronous to CORE_CLK
// Notes:   New settings take effect only while the system clock is low
//
// Summary of operation
// - Select 11: system clock follows external input
// - Select 10, bypass 1: oscillator over prescaler
// - Prescaler from crystal or internal; factor field+1
// - Factor one passes oscillator clock undivided
// - Largest prescale factor is 1024
// - Crystal bypass, factor one equals direct drive
// - One selected clock drives all logic
// - Select 10, bypass 0: PLL supplies clock
// - PLL factor N over P times K2
// - Select 00: wakeup clock drives system clock
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "clk_src_regs.svh"
module system_clock_source_select
  import clk_src_pkg::*;
(
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST_N,
  // Register port
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WR_DATA,
  input  wire logic        WR_EN,
  input  wire logic        RD_EN,
  output logic      [31:0] RD_DATA,
  // Raw clock sources
  input  wire logic        EXT_CLOCK_INPUT,
  input  wire logic        CRYSTAL_INPUT,
  input  wire logic        INTERNAL_CLOCK,
  input  wire logic        WAKEUP_CLOCK,
  // System clock
  output logic             SYS_CLK
);

  clk_cfg_t   req;
  clk_cfg_t   act;
  clk_mode_t  act_mode;
  logic       pending;
  logic       adopt;
  logic       armed;
  logic       ext_q;
  logic       xtal_q;
  logic       int_q;
  logic       wu_q;
  logic       osc_raw;
  logic       osc_q;
  clk_edge_t  ext_e;
  clk_edge_t  osc_e;
  clk_edge_t  wu_e;
  clk_edge_t  div_e;
  clk_edge_t  nco_e;
  clk_edge_t  sel_e;
  logic       arm_fall;
  logic [31:0] rd_value;

  // Reset configuration, identical for requested and applied settings
  localparam logic [31:0] sys_ctrl_rst = `SYSTEM_CONTROL_RST;
  localparam logic [31:0] pll_ctrl_rst = `PLL_CONTROL_RST;
  localparam logic [31:0] out_div_rst  = `PLL_OUT_DIVIDE_RST;
  localparam clk_cfg_t    cfg_rst      = '{
    clock_source_select:     sys_ctrl_rst[`SEL_LSB +: `SEL_W],
    vco_bypass:              pll_ctrl_rst[`BYPASS_BIT],
    osc_internal:            pll_ctrl_rst[`OSC_INTERNAL_BIT],
    prescale_divide_field:   pll_ctrl_rst[`PRESCALE_LSB +: `PRESCALE_W],
    pll_input_divide_field:  pll_ctrl_rst[`PLL_IN_DIV_LSB +: `PLL_IN_DIV_W],
    pll_multiplier_field:    pll_ctrl_rst[`PLL_MUL_LSB +: `PLL_MUL_W],
    pll_output_divide_field: out_div_rst[`PLL_OUT_DIV_LSB +: `PLL_OUT_DIV_W]
  };

  // ==========================================================================
  // Source sampling
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      ext_q  <= 1'b0;
      xtal_q <= 1'b0;
      int_q  <= 1'b0;
      wu_q   <= 1'b0;
    end else begin
      ext_q  <= EXT_CLOCK_INPUT;
      xtal_q <= CRYSTAL_INPUT;
      int_q  <= INTERNAL_CLOCK;
      wu_q   <= WAKEUP_CLOCK;
    end
  end

  // Oscillator from crystal or internal source
  assign osc_raw = act.osc_internal ? INTERNAL_CLOCK : CRYSTAL_INPUT;
  assign osc_q   = act.osc_internal ? int_q : xtal_q;

  // Edge events
  always_comb begin
    ext_e.rise = EXT_CLOCK_INPUT && !ext_q;
    ext_e.fall = !EXT_CLOCK_INPUT && ext_q;
    osc_e.rise = osc_raw && !osc_q;
    osc_e.fall = !osc_raw && osc_q;
    wu_e.rise  = WAKEUP_CLOCK && !wu_q;
    wu_e.fall  = !WAKEUP_CLOCK && wu_q;
  end

  // ==========================================================================
  // Mode decode
  always_comb begin
    if (act.clock_source_select == `SEL_DIRECT) begin
      act_mode = MODE_DIRECT;
    end else if (act.clock_source_select == `SEL_PRESCALE_PLL && act.vco_bypass) begin
      act_mode = MODE_PRESCALE;
    end else if (act.clock_source_select == `SEL_PRESCALE_PLL) begin
      act_mode = MODE_PLL;
    end else begin
      act_mode = MODE_WAKEUP;
    end
  end

  // Prescaler, factor field plus one, at most 1024
  edge_divider #(
    .WIDTH (`PRESCALE_W)
  ) u_prescaler (
    .clk     (CORE_CLK),
    .rst_n   (RST_N),
    .restart (!armed),
    .div_m1  (act.prescale_divide_field),
    .src     (osc_e),
    .out     (div_e)
  );

  // Synthesiser locked to the oscillator
  rate_nco #(
    .PW (16)
  ) u_pll (
    .clk      (CORE_CLK),
    .rst_n    (RST_N),
    .restart  (!armed),
    .n_m1     (act.pll_multiplier_field),
    .p_m1     (act.pll_input_divide_field),
    .k2_m1    (act.pll_output_divide_field),
    .src_rise (osc_e.rise),
    .out      (nco_e)
  );

  // Selected edge stream and its arming edge
  always_comb begin
    case (act_mode)
      MODE_DIRECT: begin
        sel_e    = ext_e;
        arm_fall = ext_e.fall;
      end
      MODE_PRESCALE: begin
        sel_e    = div_e;
        arm_fall = osc_e.fall;
      end
      MODE_PLL: begin
        sel_e    = nco_e;
        arm_fall = osc_e.fall;
      end
      default: begin
        sel_e    = wu_e;
        arm_fall = wu_e.fall;
      end
    endcase
  end

  // ==========================================================================
  // Glitch-free switching: adopt only while low, then wait for a source fall
  assign pending = (req != act);
  assign adopt   = pending && !SYS_CLK;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      act <= cfg_rst;
    end else if (adopt) begin
      act <= req;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || adopt) begin
      armed <= 1'b0;
    end else if (arm_fall) begin
      armed <= 1'b1;
    end
  end

  // System clock output
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || adopt) begin
      SYS_CLK <= 1'b0;
    end else if (armed && sel_e.rise) begin
      SYS_CLK <= 1'b1;
    end else if (sel_e.fall) begin
      SYS_CLK <= 1'b0;
    end
  end

  // ==========================================================================
  // Register writes
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      req <= cfg_rst;
    end else if (WR_EN) begin
      if (ADDR == `OFS_SYSTEM_CONTROL) begin
        req.clock_source_select <= WR_DATA[`SEL_LSB +: `SEL_W];
      end else if (ADDR == `OFS_PLL_CONTROL) begin
        req.vco_bypass             <= WR_DATA[`BYPASS_BIT];
        req.osc_internal           <= WR_DATA[`OSC_INTERNAL_BIT];
        req.prescale_divide_field  <= WR_DATA[`PRESCALE_LSB +: `PRESCALE_W];
        req.pll_input_divide_field <= WR_DATA[`PLL_IN_DIV_LSB +: `PLL_IN_DIV_W];
        req.pll_multiplier_field   <= WR_DATA[`PLL_MUL_LSB +: `PLL_MUL_W];
      end else if (ADDR == `OFS_PLL_OUT_DIVIDE) begin
        req.pll_output_divide_field <= WR_DATA[`PLL_OUT_DIV_LSB +: `PLL_OUT_DIV_W];
      end
    end
  end

  // Read decode
  always_comb begin
    rd_value = 32'h0000_0000;
    if (ADDR == `OFS_SYSTEM_CONTROL) begin
      rd_value[`SEL_LSB +: `SEL_W] = req.clock_source_select;
    end else if (ADDR == `OFS_PLL_CONTROL) begin
      rd_value[`BYPASS_BIT]             = req.vco_bypass;
      rd_value[`OSC_INTERNAL_BIT]       = req.osc_internal;
      rd_value[`PRESCALE_LSB +: `PRESCALE_W]     = req.prescale_divide_field;
      rd_value[`PLL_IN_DIV_LSB +: `PLL_IN_DIV_W] = req.pll_input_divide_field;
      rd_value[`PLL_MUL_LSB +: `PLL_MUL_W]       = req.pll_multiplier_field;
    end else if (ADDR == `OFS_PLL_OUT_DIVIDE) begin
      rd_value[`PLL_OUT_DIV_LSB +: `PLL_OUT_DIV_W] = req.pll_output_divide_field;
    end else if (ADDR == `OFS_CLOCK_STATUS) begin
      rd_value[1:0] = act.clock_source_select;
      rd_value[2]   = act.vco_bypass;
      rd_value[3]   = act.osc_internal;
      rd_value[4]   = pending;
      rd_value[5]   = armed;
      rd_value[6]   = SYS_CLK;
    end
  end

  // Read data for one cycle
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || !RD_EN) begin
      RD_DATA <= 32'h0000_0000;
    end else begin
      RD_DATA <= rd_value;
    end
  end

  // ==========================================================================
  // Checks
  logic        seen;
  logic [10:0] src_cnt;

  // Oscillator rises per prescaled period
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N || !armed || act_mode != MODE_PRESCALE) begin
      seen    <= 1'b0;
      src_cnt <= 11'h000;
    end else if (div_e.rise) begin
      seen    <= 1'b1;
      src_cnt <= 11'h001;
    end else if (osc_e.rise) begin
      src_cnt <= src_cnt + 11'h001;
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  direct_follow_a: assert property (
    (act_mode == MODE_DIRECT && armed && !pending && ext_e.rise) |=> SYS_CLK)
    else $error("direct drive rise not followed");
  prescale_source_a: assert property (
    $rose(SYS_CLK) && act_mode == MODE_PRESCALE |-> $past(div_e.rise))
    else $error("prescaled rise without divider rise");
  prescale_count_a: assert property (
    (act_mode == MODE_PRESCALE && armed && seen && div_e.rise)
    |-> src_cnt == {1'b0, act.prescale_divide_field} + 11'h001)
    else $error("prescale period has wrong source count");
  unit_factor_a: assert property (
    (act_mode == MODE_PRESCALE && act.prescale_divide_field == '0 && armed && !pending)
    |-> (osc_e.rise |=> SYS_CLK) and (osc_e.fall |=> !SYS_CLK))
    else $error("factor one does not pass oscillator");
  max_factor_a: assert property (
    act_mode == MODE_PRESCALE |-> src_cnt <= `PRESCALE_MAX)
    else $error("prescale count beyond largest factor");
  crystal_bypass_a: assert property (
    (act_mode == MODE_PRESCALE && !act.osc_internal && act.prescale_divide_field == '0
     && armed && !pending && CRYSTAL_INPUT && !xtal_q) |=> SYS_CLK)
    else $error("crystal bypass differs from direct drive");
  single_source_a: assert property (
    $changed(SYS_CLK) |-> $past(sel_e.rise || sel_e.fall || adopt))
    else $error("system clock moved without selected source");
  pll_drive_a: assert property (
    (act_mode == MODE_PLL && armed && !pending && nco_e.rise) |=> SYS_CLK)
    else $error("synthesiser rise not followed");
  wakeup_follow_a: assert property (
    (act_mode == MODE_WAKEUP && armed && !pending && wu_e.fall) |=> !SYS_CLK)
    else $error("wakeup fall not followed");
  switch_quiet_a: assert property (
    adopt |-> !SYS_CLK ##1 (!SYS_CLK && !armed) ##1 !SYS_CLK)
    else $error("clock pulse shortened at switch");

  switch_c:   cover property (adopt);
  pll_c:      cover property (act_mode == MODE_PLL && $rose(SYS_CLK));
  max_div_c:  cover property (act.prescale_divide_field == 10'h3FF && $rose(SYS_CLK));
  direct_c:   cover property (act_mode == MODE_DIRECT && $rose(SYS_CLK));

endmodule
`default_nettype wire

/* tb/tb_system_clock_source_select.sv */
// Purpose: Self-checking bench for the system clock source selector
// Assumes: Clock sources are built here as levels synchronous to CORE_CLK
// Notes:   SYS_CLK high time and period are measured in core cycles
`timescale 1ns/100ps
`default_nettype none
`include "clk_src_regs.svh"
module tb_system_clock_source_select;
  // ==========================================================================
  // Signals
  logic        core_clk;
  logic        rst_n;
  logic [7:0]  addr;
  logic [31:0] wr_data;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] rd_data;
  logic        ext_clk;
  logic        xtal_clk;
  logic        int_clk;
  logic        wu_clk;
  logic        sys_clk;
  int          mismatches;
  int          checked;
  int          src_cnt;
  int          run_len;
  int          min_run;
  logic        seen;
  logic        last_clk;
  logic [31:0] rv;

  system_clock_source_select u_dut (
    .CORE_CLK        (core_clk),
    .RST_N           (rst_n),
    .ADDR            (addr),
    .WR_DATA         (wr_data),
    .WR_EN           (wr_en),
    .RD_EN           (rd_en),
    .RD_DATA         (rd_data),
    .EXT_CLOCK_INPUT (ext_clk),
    .CRYSTAL_INPUT   (xtal_clk),
    .INTERNAL_CLOCK  (int_clk),
    .WAKEUP_CLOCK    (wu_clk),
    .SYS_CLK         (sys_clk)
  );

  // ==========================================================================
  // Core clock, 5 ns period
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Raw sources: ext 3/5, crystal 3/2, internal 3/3, wakeup 10/10
  always @(posedge core_clk) begin
    src_cnt  <= src_cnt + 1;
    ext_clk  <= ((src_cnt + 1) % 8) < 3;
    xtal_clk <= ((src_cnt + 1) % 5) < 3;
    int_clk  <= ((src_cnt + 1) % 6) < 3;
    wu_clk   <= ((src_cnt + 1) % 20) < 10;
  end

  // Shortest completed high or low run of the system clock
  always @(posedge core_clk) begin
    if (rst_n !== 1'b1) begin
      seen    <= 1'b0;
      run_len <= 0;
    end else if (sys_clk !== last_clk) begin
      if (seen && run_len < min_run) min_run <= run_len;
      seen    <= 1'b1;
      run_len <= 1;
    end else begin
      run_len <= run_len + 1;
    end
    last_clk <= sys_clk;
  end

  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v, input string msg);
    checked++;
    if (seen_v !== exp_v) begin
      mismatches++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen_v, exp_v);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    wr_en   <= 1'b1;
    addr    <= a;
    wr_data <= d;
    @(posedge core_clk);
    wr_en   <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge core_clk);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask

  task automatic cfg(input logic [1:0] sel, input logic byp, input logic osc,
                     input logic [9:0] pre, input logic [3:0] p, input logic [7:0] n,
                     input logic [6:0] k2);
    wr(`OFS_PLL_CONTROL, {4'h0, n, p, 2'h0, pre, 2'h0, osc, byp});
    wr(`OFS_PLL_OUT_DIVIDE, {25'h0, k2});
    wr(`OFS_SYSTEM_CONTROL, {30'h0, sel});
  endtask

  // Skip four periods, then check one period, and the high time when tol is zero
  task automatic clk_shape(input int hi_e, input int per_e, input int tol, input string msg);
    int hi;
    int per;
    repeat (4) begin
      while (sys_clk !== 1'b0) @(posedge core_clk);
      while (sys_clk !== 1'b1) @(posedge core_clk);
    end
    hi = 0;
    while (sys_clk === 1'b1) begin
      @(posedge core_clk);
      hi++;
    end
    per = hi;
    while (sys_clk === 1'b0) begin
      @(posedge core_clk);
      per++;
    end
    if (tol == 0) check(32'(hi), 32'(hi_e), msg);
    check(32'((per >= per_e - tol) && (per <= per_e + tol)), 32'h0000_0001, msg);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_regs;
    rd(`OFS_SYSTEM_CONTROL, rv);
    check(rv, `SYSTEM_CONTROL_RST, "select reset");
    rd(`OFS_PLL_CONTROL, rv);
    check(rv, `PLL_CONTROL_RST, "pll control reset");
    rd(`OFS_PLL_OUT_DIVIDE, rv);
    check(rv, `PLL_OUT_DIVIDE_RST, "out divide reset");
    rd(8'h10, rv);
    check(rv, 32'h0000_0000, "unmapped read");
    wr(`OFS_CLOCK_STATUS, 32'h0000_0003);
    rd(`OFS_CLOCK_STATUS, rv);
    check(rv & 32'h0000_0003, 32'h0000_0000, "status write ignored");
    wr(`OFS_PLL_CONTROL, 32'h0A53_0231);
    rd(`OFS_PLL_CONTROL, rv);
    check(rv, 32'h0A53_0231, "control readback");
    @(posedge core_clk);
    #1;
    check(rd_data, 32'h0000_0000, "read data cleared after one cycle");
  endtask

  task automatic t_direct;
    cfg(2'h3, 1'b1, 1'b0, 10'h000, 4'h0, 8'h00, 7'h00);
    clk_shape(3, 8, 0, "direct drive shape");
    rd(`OFS_CLOCK_STATUS, rv);
    check(rv & 32'h0000_0013, 32'h0000_0003, "direct applied");
  endtask

  task automatic t_presc;
    cfg(2'h2, 1'b1, 1'b0, 10'h000, 4'h0, 8'h00, 7'h00);
    clk_shape(3, 5, 0, "crystal factor one");
    clk_shape(3, 5, 0, "crystal bypass as direct");
    cfg(2'h2, 1'b1, 1'b1, 10'h000, 4'h0, 8'h00, 7'h00);
    clk_shape(3, 6, 0, "internal factor one");
    cfg(2'h2, 1'b1, 1'b1, 10'h001, 4'h0, 8'h00, 7'h00);
    clk_shape(6, 12, 0, "internal factor two");
    cfg(2'h2, 1'b1, 1'b0, 10'h002, 4'h0, 8'h00, 7'h00);
    clk_shape(5, 15, 0, "crystal factor three");
    cfg(2'h2, 1'b1, 1'b0, 10'h003, 4'h0, 8'h00, 7'h00);
    clk_shape(10, 20, 0, "crystal factor four");
  endtask

  task automatic t_pll;
    cfg(2'h2, 1'b0, 1'b0, 10'h000, 4'h0, 8'h01, 7'h03);
    repeat (200) @(posedge core_clk);
    clk_shape(0, 10, 1, "pll two over four");
    cfg(2'h2, 1'b0, 1'b0, 10'h000, 4'h1, 8'h00, 7'h02);
    repeat (200) @(posedge core_clk);
    clk_shape(0, 30, 1, "pll one over six");
  endtask

  task automatic t_wakeup;
    cfg(2'h0, 1'b1, 1'b0, 10'h000, 4'h0, 8'h00, 7'h00);
    clk_shape(10, 20, 0, "wakeup drive");
  endtask

  task automatic t_switch;
    min_run = 1000000;
    for (int i = 0; i < 6; i++) begin
      cfg(2'(i % 4), 1'b1, 1'(i % 2), 10'(i), 4'h0, 8'h00, 7'h00);
      repeat (7 + 3 * i) @(posedge core_clk);
    end
    repeat (100) @(posedge core_clk);
    check(32'(min_run >= 2), 32'h0000_0001, "shortest pulse on switching");
  endtask

  task automatic t_max;
    cfg(2'h2, 1'b1, 1'b0, 10'h3FF, 4'h0, 8'h00, 7'h00);
    clk_shape(2560, 5120, 0, "largest prescale");
  endtask

  // ==========================================================================
  // Verdict
  task automatic stop_test;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    mismatches = 0;
    checked    = 0;
    min_run    = 1000000;
    src_cnt    = 0;
    rst_n      = 1'b0;
    addr       = 8'h00;
    wr_data    = 32'h0000_0000;
    wr_en      = 1'b0;
    rd_en      = 1'b0;
    ext_clk    = 1'b0;
    xtal_clk   = 1'b0;
    int_clk    = 1'b0;
    wu_clk     = 1'b0;
    last_clk   = 1'b0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    t_regs();
    t_direct();
    t_presc();
    t_pll();
    t_wakeup();
    t_switch();
    t_max();
    stop_test();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (90000) @(posedge core_clk);
    mismatches++;
    $display("wrong value at %0t: run did not finish", $time);
    stop_test();
  end
endmodule
`default_nettype wire
